// ===== hdl/capture_compare_timer.sv
/*
  Sixteen-bit capture/compare timer with APB register access, input capture
  with noise filter, buffered compares and six gated waveform outputs.
  Assumes external pins and ring clocks are asynchronous; port_data comes
  from the port controller on clk; events go to an outside interrupt unit.
*/
`timescale 1ns/1ps
module capture_compare_timer #(
  parameter int COUNT_W = timer_pkg::COUNT_W,
  parameter int NUM_OUT = timer_pkg::NUM_OUT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pulse_input_pin,
  input wire logic slow_ring_clock,
  input wire logic fast_ring_clock,
  input wire logic [NUM_OUT-1:0] port_data,
  output logic [NUM_OUT-1:0] compare_wave_output,
  output logic capture_event_input,
  output logic overflow_event,
  output logic compare0_event,
  output logic compare1_event
);
  logic [7:0] ctrl_one_reg;
  logic [7:0] ctrl_two_reg;
  logic [7:0] wave_ctrl_reg;
  logic [COUNT_W-1:0] count_reg;
  logic [COUNT_W-1:0] count_next;
  logic [COUNT_W-1:0] cc0_reg;
  logic [COUNT_W-1:0] cmp1_reg;
  logic [COUNT_W-1:0] cc0_buf_reg;
  logic [COUNT_W-1:0] cmp1_buf_reg;
  logic [timer_pkg::PRE_W-1:0] pre_reg;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic fast_prev_reg;
  logic trig_prev_reg;
  logic wave_reg;
  logic wave_next;
  logic run;
  logic mode_cmp;
  logic reload;
  logic fast_tick;
  logic tick;
  logic hit0;
  logic hit1;
  logic ovf;
  logic load_now;
  logic trig_level;
  logic filt_level;
  logic filt_tick;
  logic edge_seen;
  logic cap_hit;
  logic wr_en;
  logic rd_setup;
  logic hit_counter;
  logic hit_cc0;
  logic hit_cmp1;
  logic hit_ctrl_one;
  logic hit_ctrl_two;
  logic hit_wave;
  logic mapped;
  logic [31:0] rd_value;
  timer_pkg::count_src_t src_sel;
  timer_pkg::filter_t filt_sel;
  timer_pkg::edge_t edge_sel;
  timer_pkg::action_t act0;
  timer_pkg::action_t act1;

  initial begin
    if (COUNT_W < 8 || COUNT_W > 32) begin
      $error("COUNT_W must lie between 8 and 32");
    end
    if (NUM_OUT < 1 || NUM_OUT > 6) begin
      $error("NUM_OUT must lie between 1 and 6");
    end
  end

  // Strobe for one of the prescaled rates; shared by counter and filter
  function automatic logic rate_tick(input logic [1:0] sel,
                                     input logic [timer_pkg::PRE_W-1:0] pre,
                                     input logic fast);
    logic t;
    t = 1'b0;
    case (sel)
      timer_pkg::SRC_F1: t = 1'b1;
      timer_pkg::SRC_F8: t = (pre[2:0] == timer_pkg::DIV8_MASK);
      timer_pkg::SRC_F32: t = (pre == timer_pkg::DIV32_MASK);
      default: t = fast;
    endcase
    return t;
  endfunction

  function automatic logic addr_is(input logic [timer_pkg::ADDR_W-1:0] a,
                                   input logic [7:0] idx);
    return a == {{(timer_pkg::ADDR_W-10){1'b0}}, idx, 2'b00};
  endfunction

  function automatic logic apply_action(input timer_pkg::action_t act,
                                        input logic cur);
    logic v;
    v = cur;
    case (act)
      timer_pkg::ACT_TOGGLE: v = !cur;
      timer_pkg::ACT_LOW: v = 1'b0;
      timer_pkg::ACT_HIGH: v = 1'b1;
      default: v = cur;
    endcase
    return v;
  endfunction

  assign run = ctrl_one_reg[timer_pkg::RUN_BIT];
  assign src_sel = timer_pkg::count_src_t'(ctrl_one_reg[timer_pkg::SRC_LSB +: 2]);
  assign edge_sel = timer_pkg::edge_t'(ctrl_one_reg[timer_pkg::EDGE_LSB +: 2]);
  assign filt_sel = timer_pkg::filter_t'(ctrl_two_reg[timer_pkg::FILT_LSB +: 2]);
  assign reload = ctrl_two_reg[timer_pkg::RELOAD_BIT];
  assign mode_cmp = ctrl_two_reg[timer_pkg::MODE_BIT];
  assign act0 = timer_pkg::action_t'(ctrl_two_reg[timer_pkg::ACT0_LSB +: 2]);
  assign act1 = timer_pkg::action_t'(ctrl_two_reg[timer_pkg::ACT1_LSB +: 2]);

  // Pins and ring clocks are asynchronous, so each passes two flops first
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else begin
      sync1_reg <= {fast_ring_clock, slow_ring_clock, pulse_input_pin};
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fast_prev_reg <= 1'b0;
    end else begin
      fast_prev_reg <= sync2_reg[2];
    end
  end

  // Fast ring clock must stay below half of clk to be seen on every edge
  assign fast_tick = sync2_reg[2] && !fast_prev_reg;

  // Free-running prescaler; runs regardless of the run bit
  always_ff @(posedge clk) begin
    if (rst) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 1'b1;
    end
  end

  assign tick = run && rate_tick(src_sel, pre_reg, fast_tick);

  // Trigger choice, then filter
  assign trig_level = ctrl_one_reg[timer_pkg::TRIG_BIT] ? sync2_reg[1] : sync2_reg[0];
  assign filt_tick = rate_tick(2'(filt_sel - 2'h1), pre_reg, fast_tick);

  noise_filter #(
    .SAMPLES(timer_pkg::FILTER_SAMPLES)
  ) u_filter (
    .clk(clk),
    .rst(rst),
    .level_in(trig_level),
    .sample_tick(filt_tick),
    .bypass(filt_sel == timer_pkg::FILT_OFF),
    .level_out(filt_level)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      trig_prev_reg <= 1'b0;
    end else begin
      trig_prev_reg <= filt_level;
    end
  end

  always_comb begin
    edge_seen = 1'b0;
    case (edge_sel)
      timer_pkg::EDGE_RISE: edge_seen = filt_level && !trig_prev_reg;
      timer_pkg::EDGE_FALL: edge_seen = !filt_level && trig_prev_reg;
      timer_pkg::EDGE_BOTH: edge_seen = filt_level != trig_prev_reg;
      default: edge_seen = 1'b0;
    endcase
  end

  // Capture right at the filtered edge, so lag is the two sync flops plus the filter delay
  assign cap_hit = run && !mode_cmp && edge_seen;

  // Compare matches only count in compare mode, on a count tick
  assign hit0 = tick && mode_cmp && (count_reg == cc0_reg);
  assign hit1 = tick && mode_cmp && (count_reg == cmp1_reg);
  assign ovf = tick && (&count_reg);

  always_comb begin
    count_next = count_reg;
    if (!run) begin
      count_next = '0;
    end else if (tick) begin
      if (reload && hit1) begin
        count_next = '0;
      end else begin
        count_next = count_reg + 1'b1;
      end
    end
  end

  // The counter is never written by software in either mode
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= timer_pkg::COUNT_RST;
    end else begin
      count_reg <= count_next;
    end
  end

  assign load_now = !run || (!reload && ovf) || (reload && hit1);

  // Buffered compare values; compare 0 buffer locked out in capture mode
  always_ff @(posedge clk) begin
    if (rst) begin
      cc0_buf_reg <= '0;
    end else if (wr_en && hit_cc0 && mode_cmp) begin
      cc0_buf_reg <= pwdata[COUNT_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cmp1_buf_reg <= '0;
    end else if (wr_en && hit_cmp1) begin
      cmp1_buf_reg <= pwdata[COUNT_W-1:0];
    end
  end

  // Register 0 doubles as capture latch and active compare 0 value
  always_ff @(posedge clk) begin
    if (rst) begin
      cc0_reg <= '0;
    end else if (!mode_cmp) begin
      if (cap_hit) begin
        cc0_reg <= count_reg;
      end
    end else if (load_now) begin
      cc0_reg <= cc0_buf_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cmp1_reg <= '0;
    end else if (load_now) begin
      cmp1_reg <= cmp1_buf_reg;
    end
  end

  // Compare 1 applied after compare 0, so it wins when both hit together
  assign wave_next = hit1 ? apply_action(act1, hit0 ? apply_action(act0, wave_reg) : wave_reg)
                          : (hit0 ? apply_action(act0, wave_reg) : wave_reg);

  always_ff @(posedge clk) begin
    if (rst) begin
      wave_reg <= 1'b0;
    end else begin
      wave_reg <= wave_next;
    end
  end

  // Output gating; a gated-off output holds a fixed low level
  generate
    for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
      localparam int INV_BIT = (i < 3) ? timer_pkg::INV_A_BIT : timer_pkg::INV_B_BIT;
      always_ff @(posedge clk) begin
        if (rst) begin
          compare_wave_output[i] <= 1'b0;
        end else if (mode_cmp && wave_ctrl_reg[i] && port_data[i]) begin
          compare_wave_output[i] <= wave_reg ^ wave_ctrl_reg[INV_BIT];
        end else begin
          compare_wave_output[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Event pulses, one cycle each
  always_ff @(posedge clk) begin
    if (rst) begin
      capture_event_input <= 1'b0;
      overflow_event <= 1'b0;
      compare0_event <= 1'b0;
      compare1_event <= 1'b0;
    end else begin
      capture_event_input <= cap_hit;
      overflow_event <= ovf;
      compare0_event <= hit0;
      compare1_event <= hit1;
    end
  end

  // APB decode
  always_comb begin
    hit_counter = 1'b0;
    hit_cc0 = 1'b0;
    hit_cmp1 = 1'b0;
    hit_ctrl_one = 1'b0;
    hit_ctrl_two = 1'b0;
    hit_wave = 1'b0;
    if (addr_is(paddr, timer_pkg::IDX_COUNTER)) begin
      hit_counter = 1'b1;
    end else if (addr_is(paddr, timer_pkg::IDX_CC0)) begin
      hit_cc0 = 1'b1;
    end else if (addr_is(paddr, timer_pkg::IDX_CMP1)) begin
      hit_cmp1 = 1'b1;
    end else if (addr_is(paddr, timer_pkg::IDX_CTRL_ONE)) begin
      hit_ctrl_one = 1'b1;
    end else if (addr_is(paddr, timer_pkg::IDX_CTRL_TWO)) begin
      hit_ctrl_two = 1'b1;
    end else if (addr_is(paddr, timer_pkg::IDX_WAVE)) begin
      hit_wave = 1'b1;
    end
  end

  assign mapped = hit_counter | hit_cc0 | hit_cmp1 | hit_ctrl_one | hit_ctrl_two | hit_wave;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_en = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;

  always_comb begin
    rd_value = 32'h0000_0000;
    if (hit_counter) begin
      rd_value[COUNT_W-1:0] = count_reg;
    end else if (hit_cc0) begin
      rd_value[COUNT_W-1:0] = cc0_reg;
    end else if (hit_cmp1) begin
      rd_value[COUNT_W-1:0] = cmp1_reg;
    end else if (hit_ctrl_one) begin
      rd_value[7:0] = ctrl_one_reg;
    end else if (hit_ctrl_two) begin
      rd_value[7:0] = ctrl_two_reg;
    end else if (hit_wave) begin
      rd_value[7:0] = wave_ctrl_reg;
    end
  end

  // Read data captured in the setup cycle, presented in the access cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rd_value;
    end
  end

  // Mode bit is taken as written; software keeps it still while running
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_one_reg <= timer_pkg::CTRL_ONE_RST;
    end else if (wr_en && hit_ctrl_one) begin
      ctrl_one_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_two_reg <= timer_pkg::CTRL_TWO_RST;
    end else if (wr_en && hit_ctrl_two) begin
      ctrl_two_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wave_ctrl_reg <= timer_pkg::WAVE_RST;
    end else if (wr_en && hit_wave) begin
      wave_ctrl_reg <= pwdata[7:0];
    end
  end
endmodule

// ===== inc/timer_pkg.sv
/*
  Shared constants for the capture/compare timer: register indices, field
  positions, reset values, prescaler masks and field encodings.
  Assumes a 32-bit APB slave where each register index maps to byte index*4.
*/
package timer_pkg;
  localparam int ADDR_W = 12;
  localparam int COUNT_W = 16;
  localparam int NUM_OUT = 6;
  localparam int FILTER_SAMPLES = 3;

  // Register indices; byte address is index times four
  localparam logic [7:0] IDX_COUNTER = 8'h90;
  localparam logic [7:0] IDX_CC0 = 8'h92;
  localparam logic [7:0] IDX_CMP1 = 8'h94;
  localparam logic [7:0] IDX_CTRL_ONE = 8'h9a;
  localparam logic [7:0] IDX_CTRL_TWO = 8'h9b;
  localparam logic [7:0] IDX_WAVE = 8'h9c;

  // timer_control_one fields
  localparam int RUN_BIT = 0;
  localparam int SRC_LSB = 1;
  localparam int EDGE_LSB = 3;
  localparam int TRIG_BIT = 7;
  // timer_control_two fields
  localparam int FILT_LSB = 0;
  localparam int RELOAD_BIT = 2;
  localparam int MODE_BIT = 3;
  localparam int ACT0_LSB = 4;
  localparam int ACT1_LSB = 6;
  // wave_output_control fields
  localparam int INV_A_BIT = 6;
  localparam int INV_B_BIT = 7;

  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] WAVE_RST = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;

  localparam int PRE_W = 5;
  localparam logic [2:0] DIV8_MASK = 3'h7;
  localparam logic [4:0] DIV32_MASK = 5'h1f;

  typedef enum logic [1:0] {SRC_F1, SRC_F8, SRC_F32, SRC_FAST} count_src_t;
  typedef enum logic [1:0] {FILT_OFF, FILT_F1, FILT_F8, FILT_F32} filter_t;
  typedef enum logic [1:0] {ACT_KEEP, ACT_TOGGLE, ACT_LOW, ACT_HIGH} action_t;
  typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_BOTH, EDGE_NONE} edge_t;
endpackage

// ===== hdl/noise_filter.sv
/*
  Digital noise filter for the capture trigger level.
  Assumes level_in is already synchronised to clk and sample_tick is a
  one-cycle strobe at the chosen sampling rate.
*/
`timescale 1ns/1ps
module noise_filter #(
  parameter int SAMPLES = timer_pkg::FILTER_SAMPLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic level_in,
  input wire logic sample_tick,
  input wire logic bypass,
  output logic level_out
);
  logic [SAMPLES-2:0] hist_reg;
  logic [SAMPLES-1:0] window;

  initial begin
    if (SAMPLES < 2) begin
      $error("noise_filter needs at least two samples");
    end
  end

  assign window = {hist_reg, level_in};

  always_ff @(posedge clk) begin
    if (rst) begin
      hist_reg <= '0;
    end else if (sample_tick) begin
      hist_reg <= window[SAMPLES-2:0];
    end
  end

  // Bypass passes the level straight through; filtered needs equal samples
  always_ff @(posedge clk) begin
    if (rst) begin
      level_out <= 1'b0;
    end else if (bypass) begin
      level_out <= level_in;
    end else if (sample_tick && ((&window) || !(|window))) begin
      level_out <= level_in;
    end
  end
endmodule

// ===== test/timer_checker.sv
/* Port assertions for capture_compare_timer.
   Bound to the design top; sees only its ports. */
`timescale 1ns/1ps
module timer_checker #(
  parameter int COUNT_W = 16,
  parameter int NUM_OUT = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pulse_input_pin,
  input wire logic slow_ring_clock,
  input wire logic fast_ring_clock,
  input wire logic [NUM_OUT-1:0] port_data,
  input wire logic [NUM_OUT-1:0] compare_wave_output,
  input wire logic capture_event_input,
  input wire logic overflow_event,
  input wire logic compare0_event,
  input wire logic compare1_event
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic [1:0] trig_q;
  logic [7:0] age_reg;
  logic [16:0] ovf_age_reg;
  always_ff @(posedge clk) begin
    trig_q <= {pulse_input_pin, slow_ring_clock};
  end
  // Ages saturate, so a stale trigger can never excuse a late capture
  always_ff @(posedge clk) begin
    if (rst) begin
      age_reg <= 8'hff;
    end else if (trig_q != {pulse_input_pin, slow_ring_clock}) begin
      age_reg <= 8'h00;
    end else if (age_reg != 8'hff) begin
      age_reg <= age_reg + 8'h01;
    end
  end
  always_ff @(posedge clk) begin
    if (rst || overflow_event) begin
      ovf_age_reg <= 17'h00000;
    end else if (ovf_age_reg != 17'h1ffff) begin
      ovf_age_reg <= ovf_age_reg + 17'h00001;
    end
  end
  sequence one_pulse(logic s);
    s ##1 !s;
  endsequence
  a_capture_single: assert property (capture_event_input |-> one_pulse(capture_event_input))
    else $error("capture event too long");
  a_overflow_single: assert property (overflow_event |-> one_pulse(overflow_event))
    else $error("overflow event too long");
  a_cmp0_single: assert property (compare0_event |-> one_pulse(compare0_event))
    else $error("compare 0 event too long");
  a_cmp1_single: assert property (compare1_event |-> one_pulse(compare1_event))
    else $error("compare 1 event too long");
  a_capture_lag: assert property (capture_event_input |-> age_reg <= 8'ha0)
    else $error("capture without recent edge");
  a_overflow_spacing: assert property (overflow_event |-> ovf_age_reg >= 17'h0ffff)
    else $error("overflow too early");
  a_gated_low: assert property ((compare_wave_output
    & ~(port_data | $past(port_data) | $past(port_data, 2))) == '0)
    else $error("gated output not low");
  a_error_read_zero: assert property (pslverr |-> psel && penable && prdata == 32'h0)
    else $error("error response malformed");
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_reset_quiet: assert property ($fell(rst) |-> !overflow_event && !compare0_event
    && !compare1_event && !capture_event_input && compare_wave_output == '0)
    else $error("outputs busy after reset");
endmodule

bind capture_compare_timer timer_checker #(.COUNT_W(COUNT_W), .NUM_OUT(NUM_OUT)) u_checker (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pulse_input_pin(pulse_input_pin), .slow_ring_clock(slow_ring_clock),
  .fast_ring_clock(fast_ring_clock), .port_data(port_data),
  .compare_wave_output(compare_wave_output), .capture_event_input(capture_event_input),
  .overflow_event(overflow_event), .compare0_event(compare0_event),
  .compare1_event(compare1_event));

// ===== test/pulse_source_model.sv
/* Far side: measured pulse source and the two ring oscillators.
   Assumes the bench calls drive() to shape the pulse. */
`timescale 1ns/1ps
module pulse_source_model (
  input wire logic clk,
  output logic pulse_input_pin,
  output logic slow_ring_clock,
  output logic fast_ring_clock
);
  initial begin
    pulse_input_pin = 1'b0;
    slow_ring_clock = 1'b0;
    fast_ring_clock = 1'b0;
  end
  // Oscillators run free, phase unrelated to clk; fast period stays above 4 clk
  always #31 fast_ring_clock = ~fast_ring_clock;
  always #1003 slow_ring_clock = ~slow_ring_clock;
  task automatic drive(input logic lvl, input int n);
    @(posedge clk);
    pulse_input_pin <= lvl;
    repeat (n) @(posedge clk);
  endtask
endmodule

// ===== test/capture_compare_timer_tb.sv
/* Self-checking bench for capture_compare_timer over APB.
   Assumes the pulse source model and bound checker are compiled first. */
`timescale 1ns/1ps
module capture_compare_timer_tb;
  localparam logic [7:0] CT = timer_pkg::IDX_COUNTER;
  localparam logic [7:0] C0 = timer_pkg::IDX_CC0;
  localparam logic [7:0] M1 = timer_pkg::IDX_CMP1;
  localparam logic [7:0] K1 = timer_pkg::IDX_CTRL_ONE;
  localparam logic [7:0] K2 = timer_pkg::IDX_CTRL_TWO;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, slv, w;
  logic [timer_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rdv, v0;
  logic pulse_input_pin, slow_ring_clock, fast_ring_clock;
  logic [5:0] port_data, wave_out;
  logic [7:0] wv;
  logic [15:0] lfsr_reg;
  wire logic [3:0] evs;
  logic [1:0] a0s [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
  logic [1:0] a1s [5] = '{2'h2, 2'h3, 2'h3, 2'h1, 2'h0};
  int err_total, tests_run, cyc, c, t0, ex;
  int ev_cnt [4];
  int ev_at [4];
  capture_compare_timer u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pulse_input_pin(pulse_input_pin), .slow_ring_clock(slow_ring_clock),
    .fast_ring_clock(fast_ring_clock), .port_data(port_data), .compare_wave_output(wave_out),
    .capture_event_input(evs[0]), .overflow_event(evs[1]), .compare0_event(evs[2]),
    .compare1_event(evs[3]));
  pulse_source_model u_src (.clk(clk), .pulse_input_pin(pulse_input_pin),
    .slow_ring_clock(slow_ring_clock), .fast_ring_clock(fast_ring_clock));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Events are logged on the falling edge, away from the driving edge
  always @(negedge clk) begin
    cyc++;
    for (int k = 0; k < 4; k++) begin
      if (evs[k] === 1'b1) begin
        ev_cnt[k]++;
        ev_at[k] = cyc;
      end
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic nxt(input logic [1:0] a, input logic cur);
    return (a == 2'h1) ? ~cur : (a == 2'h2) ? 1'b0 : (a == 2'h3) ? 1'b1 : cur;
  endfunction
  function automatic logic [5:0] out_exp(input logic v, input logic [7:0] m, input logic [5:0] p);
    return {{3{v ^ m[7]}}, {3{v ^ m[6]}}} & m[5:0] & p;
  endfunction
  function automatic int dv(input int f);
    return (f == 3) ? 32 : (f == 2) ? 8 : 1;
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic near(input string what, input logic [31:0] s, input int lo, input int hi);
    chk(what, {31'h0, (s >= lo && s <= hi)}, 32'h1);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 50) begin
        chk("pready", 32'h0, 32'h1);
        summarize();
      end
    end while (pready !== 1'b1);
    rdv = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    apb(1'b1, idx, {16'h0000, d});
  endtask
  task automatic wait_ev(input int k, input int lim);
    int c0;
    int n;
    c0 = ev_cnt[k];
    n = 0;
    while (ev_cnt[k] == c0) begin
      @(posedge clk);
      n++;
      if (n > lim) begin
        chk("event wait", 32'h0, 32'h1);
        summarize();
      end
    end
  endtask
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    port_data = 6'h00;
    lfsr_reg = 16'h005d;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, K2, 32'h0);
    chk("control two reset", rdv, 32'h0);
    apb(1'b0, 8'h91, 32'h0);
    chk("unmapped error", {31'h0, slv}, 32'h1);
    for (int s = 0; s < 4; s++) begin
      wr(K1, 16'(s * 2 + 1));
      apb(1'b0, CT, 32'h0);
      v0 = rdv;
      t0 = cyc;
      repeat (60) @(posedge clk);
      apb(1'b0, CT, 32'h0);
      ex = (cyc - t0) * 8 / ((s == 3) ? 62 : 8 * dv(s + 1));
      near("count rate", rdv - v0, ex - 1, ex + 1);
      wr(K1, 16'h0000);
      apb(1'b0, CT, 32'h0);
      chk("stop clears", rdv, 32'h0);
    end
    wr(CT, 16'h1234);
    apb(1'b0, CT, 32'h0);
    chk("counter write", rdv, 32'h0);
    for (int e = 0; e < 4; e++) begin
      c = ev_cnt[0];
      wr(K1, 16'(e * 8 + 1));
      u_src.drive(1'b1, 20);
      u_src.drive(1'b0, 20);
      chk("edge count", ev_cnt[0] - c, (e == 2) ? 2 : (e == 3) ? 0 : 1);
    end
    wr(K1, 16'h0000);
    wr(K1, 16'h0001);
    t0 = cyc;
    u_src.drive(1'b1, 30);
    apb(1'b0, C0, 32'h0);
    v0 = rdv;
    near("capture value", v0, ev_at[0] - t0 - 4, ev_at[0] - t0 + 1);
    wr(C0, 16'hbeef);
    apb(1'b0, C0, 32'h0);
    chk("capture write", rdv, v0);
    u_src.drive(1'b0, 10);
    for (int f = 0; f < 4; f++) begin
      wr(K1, 16'h0000);
      wr(K2, 16'(f));
      wr(K1, 16'h0001);
      c = ev_cnt[0];
      u_src.drive(1'b1, 2 * dv(f) - 2);
      u_src.drive(1'b0, 120);
      chk("glitch", ev_cnt[0] - c, (f == 0) ? 1 : 0);
      t0 = cyc;
      u_src.drive(1'b1, 0);
      wait_ev(0, 200);
      near("filter lag", ev_at[0] - t0, (f == 0) ? 0 : 2 * dv(f), 4 * dv(f) + 8);
      u_src.drive(1'b0, 120);
    end
    wr(K1, 16'h0000);
    wr(K2, 16'h0000);
    wr(K1, 16'h0091);
    c = ev_cnt[0];
    repeat (300) @(posedge clk);
    chk("ring trigger", {31'h0, (ev_cnt[0] - c >= 2)}, 32'h1);
    // Wave state is never reset between passes, so the bench tracks it
    w = 1'b0;
    for (int i = 0; i < 5; i++) begin
      lfsr_reg = lfsr(lfsr_reg);
      wv = {lfsr_reg[7:6], 6'h3f};
      wr(K1, 16'h0000);
      port_data <= lfsr_reg[13:8];
      wr(timer_pkg::IDX_WAVE, {8'h00, wv});
      // Mode first: compare 0 writes are ignored in capture mode
      wr(K2, {8'h00, a1s[i], a0s[i], 4'hc});
      wr(C0, 16'h000a);
      wr(M1, 16'h0014);
      wr(K1, 16'h0001);
      wait_ev(3, 100);
      wait_ev(2, 100);
      repeat (3) @(posedge clk);
      w = nxt(a0s[i], nxt(a1s[i], nxt(a0s[i], w)));
      chk("compare 0 out", wave_out, out_exp(w, wv, port_data));
      t0 = ev_at[3];
      wait_ev(3, 100);
      chk("reload period", ev_at[3] - t0, 21);
      repeat (3) @(posedge clk);
      w = nxt(a1s[i], w);
      chk("compare 1 out", wave_out, out_exp(w, wv, port_data));
    end
    wr(M1, 16'h001e);
    wait_ev(3, 100);
    t0 = ev_at[3];
    wait_ev(3, 100);
    chk("buffered compare", ev_at[3] - t0, 31);
    wr(K1, 16'h0000);
    wr(K2, 16'h0008);
    wr(C0, 16'h0005);
    wr(K1, 16'h0001);
    t0 = cyc;
    wr(C0, 16'h0009);
    wait_ev(1, 70000);
    near("overflow time", ev_at[1] - t0, 65530, 65540);
    t0 = ev_at[1];
    wait_ev(2, 40);
    near("compare after wrap", ev_at[2] - t0, 9, 10);
    summarize();
  end
endmodule
